// *** dv/t8pwm_pin_model.sv ***
// Count pin source standing in for an external event generator.
// Assumes the caller chooses the spacing; the pin idles low.
`timescale 1ns/1ps
module t8pwm_pin_model
(
	input  wire logic sys_clk,
	output logic      pin
);
	initial pin = 1'h0;
	task automatic drive(input logic b, input int gap);
		repeat (gap) @(posedge sys_clk);
		pin <= b;
	endtask
endmodule

// *** dv/t8pwm_properties.sv ***
// Port checker for the 8-bit timer: read-back, enables, forces, flag clears.
// Assumes one register strobe at a time and a synchronous active-low reset.
`timescale 1ns/1ps
module t8pwm_properties
(
	input wire logic       sys_clk,
	input wire logic       reset_n,
	input wire logic [2:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic       reg_wr,
	input wire logic       reg_rd,
	input wire logic [7:0] reg_rdata,
	input wire logic       global_irq_en,
	input wire logic [2:0] irq_ack,
	input wire logic [2:0] irq_req,
	input wire logic       wave_out_a,
	input wire logic       wave_en_a_n
);
	reg [7:0] ca_reg;
	reg [3:0] cb_reg;
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!reset_n);
	// Shadows, so a force is judged only with the counter stopped
	always @(posedge sys_clk)
		if (!reset_n)
		begin
			ca_reg <= 8'h00;
			cb_reg <= 4'h0;
		end
		else if (reg_wr && reg_addr == 3'h0)
			ca_reg <= reg_wdata;
		else if (reg_wr && reg_addr == 3'h1)
			cb_reg <= reg_wdata[3:0];
	sequence s_force_a;
		reg_wr && reg_addr == 3'h1 && reg_wdata[7] && reg_wdata[3:0] == 4'h0
			&& cb_reg == 4'h0 && !ca_reg[0];
	endsequence
	AST_GIE_GATE: assert property (!global_irq_en |-> irq_req == 3'h0)
		else $error("irq without gie");
	AST_CTRLB_RD: assert property (reg_rd && reg_addr == 3'h1 |=> reg_rdata[7:4] == 4'h0)
		else $error("ctrl_b high bits");
	AST_IRQ_RD: assert property (reg_rd && reg_addr inside {3'h5, 3'h6}
		|=> reg_rdata[7:3] == 5'h00) else $error("irq reg high bits");
	AST_EN_A: assert property (wave_en_a_n == (ca_reg[7:6] == 2'h0))
		else $error("enable a");
	AST_FORCE_SET: assert property (s_force_a ##0 ca_reg[7]
		|=> wave_out_a == $past(ca_reg[6])) else $error("force level");
	AST_FORCE_TGL: assert property (s_force_a ##0 ca_reg[7:6] == 2'h1
		|=> wave_out_a != $past(wave_out_a)) else $error("force toggle");
	AST_ACK_CLR: assert property (irq_ack[0] && cb_reg[2:0] == 3'h0 |=> !irq_req[0])
		else $error("ack clear");
	AST_W1C: assert property (reg_wr && reg_addr == 3'h6 && reg_wdata[0]
		&& cb_reg[2:0] == 3'h0 |=> !irq_req[0]) else $error("w1c clear");
endmodule

// *** dv/tb_top.sv ***
// Top bench: register-level scenarios for the 8-bit timer, checker bound.
// Assumes the checker and count-pin model are compiled before this file.
`timescale 1ns/1ps
`define CHK(n, e, a) begin tests_run++; if ((a) !== (e)) begin fail_count++; \
	$display("FAIL %s exp %h got %h", n, e, a); end end
module tb_top;
	logic       sys_clk = '0, reset_n = '0, reg_wr = '0, reg_rd = '0, global_irq_en = '0;
	logic [2:0] reg_addr = '0, irq_ack = '0, irq_req;
	logic [7:0] reg_wdata = '0, reg_rdata, v;
	logic       ext_count_pin, wave_out_a, wave_out_b, wave_en_a_n, wave_en_b_n;
	int         fail_count = 0, tests_run = 0;
	t8pwm_timer u_dut (.sys_clk, .reset_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
		.reg_rdata, .ext_count_pin, .global_irq_en, .irq_ack, .irq_req, .wave_out_a,
		.wave_out_b, .wave_en_a_n, .wave_en_b_n);
	t8pwm_pin_model u_pin (.sys_clk, .pin(ext_count_pin));
	initial
		forever #50 sys_clk = ~sys_clk;
	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'h1;
		@(posedge sys_clk);
		reg_wr <= 1'h0;
		#1;
	endtask
	task automatic rd(input logic [2:0] a);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_rd <= 1'h1;
		@(posedge sys_clk);
		reg_rd <= 1'h0;
		#1 v = reg_rdata;
	endtask
	task automatic rdc(input logic [2:0] a, input logic [7:0] e, input string n);
		rd(a);
		`CHK(n, e, v)
	endtask
	task automatic t_regs();
		for (int i = 0; i < 8; i++)
			rdc(i[2:0], 8'h00, "reset");
		wr(3'h0, 8'hFE);
		rdc(3'h0, 8'hF2, "ctrl_a");
		wr(3'h1, 8'hF0);
		rdc(3'h1, 8'h00, "ctrl_b");
		wr(3'h5, 8'hFF);
		rdc(3'h5, 8'h07, "mask");
		wr(3'h6, 8'hFF);
		wr(3'h7, 8'h5A);
		rdc(3'h6, 8'h00, "flags");
	endtask
	task automatic t_force();
		logic [7:0] m[3] = '{8'hC0, 8'h80, 8'h40};
		logic       x[3] = '{1'h1, 1'h0, 1'h1};
		for (int i = 0; i < 3; i++)
		begin
			wr(3'h0, m[i]);
			wr(3'h1, 8'h80);
			`CHK("wave_a", x[i], wave_out_a)
		end
		wr(3'h0, 8'h20);
		wr(3'h1, 8'h40);
		`CHK("wave_b", 1'h0, wave_out_b)
		`CHK("en_b_n", 1'h0, wave_en_b_n)
		rdc(3'h6, 8'h00, "force_flag");
	endtask
	task automatic t_ovf();
		wr(3'h2, 8'hFD);
		wr(3'h1, 8'h01);
		repeat (10) @(posedge sys_clk);
		wr(3'h1, 8'h00);
		rdc(3'h6, 8'h07, "ovf_match");
		@(posedge sys_clk) global_irq_en <= 1'h1;
		#1 `CHK("irq", 3'h7, irq_req)
		@(posedge sys_clk) irq_ack <= 3'h1;
		@(posedge sys_clk) irq_ack <= 3'h0;
		rdc(3'h6, 8'h06, "ack");
		wr(3'h6, 8'h02);
		rdc(3'h6, 8'h04, "w1c");
	endtask
	task automatic t_pwm();
		logic [2:0] m;
		wr(3'h3, 8'h20);
		for (int i = 0; i < 4; i++)
		begin
			m = 3'(2 * i + 1);
			wr(3'h2, 8'h00);
			wr(3'h6, 8'h07);
			wr(3'h0, {6'h00, m[1:0]});
			wr(3'h1, {4'h0, m[2], 3'h1});
			repeat (600) @(posedge sys_clk);
			wr(3'h1, {4'h0, m[2], 3'h0});
			rd(3'h2);
			`CHK("pwm_top", 1'h1, v <= (m[2] ? 8'h20 : 8'hFF))
			rd(3'h6);
			`CHK("pwm_ovf", 1'h1, v[0])
		end
	endtask
	task automatic t_ext();
		wr(3'h2, 8'h00);
		wr(3'h1, 8'h07);
		for (int i = 0; i < 5; i++)
			u_pin.drive(~i[0], 4);
		repeat (6) @(posedge sys_clk);
		wr(3'h1, 8'h06);
		for (int i = 0; i < 4; i++)
			u_pin.drive(i[0], 3);
		repeat (6) @(posedge sys_clk);
		wr(3'h1, 8'h00);
		rdc(3'h2, 8'h05, "ext");
	endtask
	task automatic t_block();
		wr(3'h0, 8'h00);
		wr(3'h4, 8'h10);
		wr(3'h6, 8'h07);
		for (int i = 0; i < 2; i++)
		begin
			wr(3'h2, 8'h10 - i[7:0]);
			repeat (10) @(posedge sys_clk);
			rdc(3'h2, 8'h10 - i[7:0], "stopped");
			wr(3'h1, 8'h01);
			wr(3'h1, 8'h00);
			rdc(3'h6, i ? 8'h04 : 8'h00, "blocked");
		end
	endtask
	task automatic t_presc();
		logic [7:0] e[4] = '{8'h80, 8'h10, 8'h04, 8'h01};
		for (int i = 0; i < 4; i++)
		begin
			wr(3'h2, 8'h00);
			wr(3'h1, 8'(i + 2));
			repeat (1024) @(posedge sys_clk);
			wr(3'h1, 8'h00);
			rd(3'h2);
			`CHK("presc", 1'h1, v >= e[i] && v <= e[i] + 8'h01)
		end
	endtask
	task automatic t_ctc();
		wr(3'h3, 8'h05);
		wr(3'h2, 8'h03);
		wr(3'h6, 8'h07);
		wr(3'h0, 8'h02);
		wr(3'h1, 8'h80);
		rdc(3'h2, 8'h03, "ctc_force_count");
		rdc(3'h6, 8'h00, "ctc_force_flag");
		wr(3'h1, 8'h01);
		repeat (9) @(posedge sys_clk);
		wr(3'h1, 8'h00);
		rdc(3'h2, 8'h02, "ctc_count");
		rdc(3'h6, 8'h02, "ctc_flags");
	endtask
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", tests_run, fail_count);
		if (fail_count == 0 && tests_run > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	initial
	begin
		repeat (12) @(posedge sys_clk);
		reset_n <= 1'h1;
		t_regs();
		t_force();
		t_ovf();
		t_pwm();
		t_ext();
		t_block();
		t_presc();
		t_ctc();
		report_and_stop();
	end
endmodule
bind t8pwm_timer t8pwm_properties u_props (.sys_clk, .reset_n, .reg_addr, .reg_wdata,
	.reg_wr, .reg_rd, .reg_rdata, .global_irq_en, .irq_ack, .irq_req, .wave_out_a,
	.wave_en_a_n);

// *** logic/t8pwm_consts.vh ***
// Constants for the 8-bit timer/counter with two compare channels.
// Assumes a register port with byte data and one-cycle read latency.
// Functional notes
// - Mode is high bit plus two low bits
// - Normal TOP FF, match-clear TOP compare A
// - Phase-correct: TOP per mode, load TOP, overflow BOTTOM
// - Fast PWM: load BOTTOM, overflow MAX or TOP
// - MAX is FF, BOTTOM is 00
// - Reserved bits read as zero
// - Force strobe matches channel in non-PWM modes
// - Forced match sets no flag, no clear
// - Force bits are strobes, read zero
// - Clock select: direct or prescaler taps
// - Select zero stops the counter
// - Codes 110/111 count falling/rising pin edges
// - Pin edges count even when pin drives
// - Counter write blocks next compare match
// - Two 8-bit compares checked continuously
// - Request needs enable, flag, global enable
// - Flags set on match and overflow
// - Flags clear on vector acknowledge
// - Writing one clears flag, zero keeps
// - Bit 2 B, bit 1 A, bit 0 overflow
// - Non-PWM output modes: off, toggle, low, high
`ifndef T8PWM_CONSTS_VH
`define T8PWM_CONSTS_VH
`define T8_ADDR_CTRL_A   3'h0
`define T8_ADDR_CTRL_B   3'h1
`define T8_ADDR_COUNT    3'h2
`define T8_ADDR_CMP_A    3'h3
`define T8_ADDR_CMP_B    3'h4
`define T8_ADDR_MASK     3'h5
`define T8_ADDR_FLAGS    3'h6
`define T8_MAX           8'hFF
`define T8_BOTTOM        8'h00
`define T8_BIT_OVF       0
`define T8_BIT_CMPA      1
`define T8_BIT_CMPB      2
`define T8_BIT_FORCE_A   7
`define T8_BIT_FORCE_B   6
`define T8_BIT_WM_HIGH   3
`define T8_DIV8          10'h007
`define T8_DIV64         10'h03F
`define T8_DIV256        10'h0FF
`define T8_DIV1024       10'h3FF
`endif

// *** logic/t8pwm_timer.v ***
// 8-bit timer/counter: registers, clock select, counter, compares, flags.
// Assumes one sys_clk; ext_count_pin is asynchronous and is synchronised here.
//
// Design decisions made here: the address map and the plain strobed port.
`timescale 1ns/1ps
`include "t8pwm_consts.vh"
module t8pwm_timer
(
	input  wire       sys_clk,
	input  wire       reset_n,
	input  wire [2:0] reg_addr,
	input  wire [7:0] reg_wdata,
	input  wire       reg_wr,
	input  wire       reg_rd,
	output reg  [7:0] reg_rdata,
	input  wire       ext_count_pin,
	input  wire       global_irq_en,
	input  wire [2:0] irq_ack,
	output wire [2:0] irq_req,
	output reg        wave_out_a,
	output reg        wave_out_b,
	output wire       wave_en_a_n,
	output wire       wave_en_b_n
);
	reg  [7:0] ctrl_a_reg;
	reg  [3:0] ctrl_b_reg;
	reg  [7:0] count_reg;
	reg  [7:0] cmp_a_reg;
	reg  [7:0] cmp_b_reg;
	reg  [7:0] cmp_a_buf_reg;
	reg  [7:0] cmp_b_buf_reg;
	reg  [2:0] mask_reg;
	reg  [2:0] flags_reg;
	reg  [9:0] presc_reg;
	reg        down_reg;
	reg        block_reg;
	reg        pin_s1_reg;
	reg        pin_s2_reg;
	reg        pin_s3_reg;
	reg  [2:0] flags_next;
	reg  [7:0] count_next;
	reg        tick;
	wire [2:0] wave_mode;
	wire [2:0] clk_source_sel;
	wire [1:0] out_mode_a;
	wire [1:0] out_mode_b;
	wire       pwm_mode;
	wire       phase_mode;
	wire [7:0] top_value;
	wire       at_top;
	wire       at_bottom;
	wire       match_a;
	wire       match_b;
	wire       ovf_event;
	wire       load_buf;
	wire       force_a;
	wire       force_b;
	wire       wr_ctrl_b;
	wire       wr_count;

	// Waveform output step for a match; PWM variants are not modelled here
	function out_step;
		input [1:0] mode;
		input       cur;
		begin
			case (mode)
				2'b01:   out_step = ~cur;
				2'b10:   out_step = 1'b0;
				2'b11:   out_step = 1'b1;
				default: out_step = cur;
			endcase
		end
	endfunction

	assign wave_mode      = {ctrl_b_reg[`T8_BIT_WM_HIGH], ctrl_a_reg[1:0]};
	assign clk_source_sel = ctrl_b_reg[2:0];
	assign out_mode_a     = ctrl_a_reg[7:6];
	assign out_mode_b     = ctrl_a_reg[5:4];
	assign pwm_mode       = (wave_mode != 3'h0) && (wave_mode != 3'h2);
	assign phase_mode     = (wave_mode == 3'h1) || (wave_mode == 3'h5);
	// Modes 4 and 6 are left to software to avoid; they fall to TOP FF here
	assign top_value = (wave_mode == 3'h2 || wave_mode == 3'h5 || wave_mode == 3'h7)
		? cmp_a_reg : `T8_MAX;
	assign at_top    = (count_reg == top_value);
	assign at_bottom = (count_reg == `T8_BOTTOM);
	// Non-PWM modes compare the live value, PWM modes the buffered one
	assign match_a = (count_reg == (pwm_mode ? cmp_a_buf_reg : cmp_a_reg)) && !block_reg;
	assign match_b = (count_reg == (pwm_mode ? cmp_b_buf_reg : cmp_b_reg)) && !block_reg;
	assign ovf_event = tick && (phase_mode ? (at_bottom && down_reg)
		: (wave_mode == 3'h7) ? at_top
		: (count_reg == `T8_MAX));
	assign load_buf = tick && (phase_mode ? at_top : at_bottom);
	assign wr_ctrl_b = reg_wr && (reg_addr == `T8_ADDR_CTRL_B);
	assign wr_count  = reg_wr && (reg_addr == `T8_ADDR_COUNT);
	assign force_a = wr_ctrl_b && reg_wdata[`T8_BIT_FORCE_A] && !pwm_mode;
	assign force_b = wr_ctrl_b && reg_wdata[`T8_BIT_FORCE_B] && !pwm_mode;
	assign irq_req = mask_reg & flags_reg & {3{global_irq_en}};
	assign wave_en_a_n = (out_mode_a == 2'b00);
	assign wave_en_b_n = (out_mode_b == 2'b00);

	// Timer clock enable; pin path uses third stage for edges only
	always @*
	begin
		case (clk_source_sel)
			3'h0:    tick = 1'b0;
			3'h1:    tick = 1'b1;
			3'h2:    tick = ((presc_reg & `T8_DIV8) == `T8_DIV8);
			3'h3:    tick = ((presc_reg & `T8_DIV64) == `T8_DIV64);
			3'h4:    tick = ((presc_reg & `T8_DIV256) == `T8_DIV256);
			3'h5:    tick = (presc_reg == `T8_DIV1024);
			3'h6:    tick = pin_s3_reg && !pin_s2_reg;
			default: tick = !pin_s3_reg && pin_s2_reg;
		endcase
	end

	always @*
	begin
		count_next = count_reg;
		if (tick)
		begin
			if (phase_mode)
			begin
				// Turn round at BOTTOM instead of wrapping to FF
				if (down_reg && !at_bottom)
					count_next = count_reg - 8'h01;
				else if (at_top)
					count_next = count_reg - 8'h01;
				else
					count_next = count_reg + 8'h01;
			end
			else if (at_top)
				count_next = `T8_BOTTOM;
			else
				count_next = count_reg + 8'h01;
		end
	end

	// Set wins over both clear paths
	always @*
	begin
		flags_next = flags_reg & ~irq_ack;
		if (reg_wr && reg_addr == `T8_ADDR_FLAGS)
			flags_next = flags_next & ~reg_wdata[2:0];
		if (tick && match_a)
			flags_next[`T8_BIT_CMPA] = 1'b1;
		if (tick && match_b)
			flags_next[`T8_BIT_CMPB] = 1'b1;
		if (ovf_event)
			flags_next[`T8_BIT_OVF] = 1'b1;
	end

	always @(posedge sys_clk)
	begin
		if (!reset_n)
		begin
			ctrl_a_reg    <= 8'h00;
			ctrl_b_reg    <= 4'h0;
			count_reg     <= 8'h00;
			cmp_a_reg     <= 8'h00;
			cmp_b_reg     <= 8'h00;
			cmp_a_buf_reg <= 8'h00;
			cmp_b_buf_reg <= 8'h00;
			mask_reg      <= 3'h0;
			flags_reg     <= 3'h0;
			presc_reg     <= 10'h000;
			down_reg      <= 1'b0;
			block_reg     <= 1'b0;
			pin_s1_reg    <= 1'b0;
			pin_s2_reg    <= 1'b0;
			pin_s3_reg    <= 1'b0;
			wave_out_a    <= 1'b0;
			wave_out_b    <= 1'b0;
			reg_rdata     <= 8'h00;
		end
		else
		begin
			pin_s1_reg <= ext_count_pin;
			pin_s2_reg <= pin_s1_reg;
			pin_s3_reg <= pin_s2_reg;
			// Free-running prescaler shared by all taps
			presc_reg <= presc_reg + 10'h001;
			flags_reg <= flags_next;
			if (wr_count)
			begin
				count_reg <= reg_wdata;
				block_reg <= 1'b1;
			end
			else
			begin
				count_reg <= count_next;
				if (tick)
					block_reg <= 1'b0;
			end
			if (tick && phase_mode)
			begin
				if (at_top)
					down_reg <= 1'b1;
				else if (at_bottom)
					down_reg <= 1'b0;
			end
			else if (!phase_mode)
				down_reg <= 1'b0;
			if (load_buf || !pwm_mode)
			begin
				cmp_a_buf_reg <= cmp_a_reg;
				cmp_b_buf_reg <= cmp_b_reg;
			end
			// Non-PWM output update; force bypasses flags and counter clear
			if (!pwm_mode && (force_a || (tick && match_a)))
				wave_out_a <= out_step(out_mode_a, wave_out_a);
			if (!pwm_mode && (force_b || (tick && match_b)))
				wave_out_b <= out_step(out_mode_b, wave_out_b);
			if (reg_wr)
			begin
				if (reg_addr == `T8_ADDR_CTRL_A)
					ctrl_a_reg <= {reg_wdata[7:4], 2'b00, reg_wdata[1:0]};
				else if (reg_addr == `T8_ADDR_CTRL_B)
					ctrl_b_reg <= reg_wdata[3:0];
				else if (reg_addr == `T8_ADDR_CMP_A)
					cmp_a_reg <= reg_wdata;
				else if (reg_addr == `T8_ADDR_CMP_B)
					cmp_b_reg <= reg_wdata;
				else if (reg_addr == `T8_ADDR_MASK)
					mask_reg <= reg_wdata[2:0];
			end
			reg_rdata <= 8'h00;
			if (reg_rd)
			begin
				if (reg_addr == `T8_ADDR_CTRL_A)
					reg_rdata <= ctrl_a_reg;
				else if (reg_addr == `T8_ADDR_CTRL_B)
					reg_rdata <= {4'h0, ctrl_b_reg};
				else if (reg_addr == `T8_ADDR_COUNT)
					reg_rdata <= count_reg;
				else if (reg_addr == `T8_ADDR_CMP_A)
					reg_rdata <= cmp_a_reg;
				else if (reg_addr == `T8_ADDR_CMP_B)
					reg_rdata <= cmp_b_reg;
				else if (reg_addr == `T8_ADDR_MASK)
					reg_rdata <= {5'h00, mask_reg};
				else if (reg_addr == `T8_ADDR_FLAGS)
					reg_rdata <= {5'h00, flags_reg};
			end
		end
	end
endmodule
